//--- cmc_pkg.sv
/*
 Package for the configuration-load controller: mode codes, states,
 timing counts and the host command carrier.
 Assumes a single 100 MHz system clock.
*/
package cmc_pkg;
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned OSC_SETTLE_US     = 100;
  localparam int unsigned OSC_SETTLE_CYC    = OSC_SETTLE_US * CLK_MHZ;
  localparam int unsigned USER_DELAY_CLKS   = 3;
  localparam int unsigned ADDR_W            = 18;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned MODE_W            = 4;
  localparam int unsigned SCAN_PINS         = 5;
  localparam int unsigned CCLK_DIV          = 8;
  localparam int unsigned ROW_BYTES         = 16;
  localparam int unsigned TOTAL_ROWS        = 4;
  localparam int unsigned MODE_CLK_EXT_BIT  = 2;
  localparam int unsigned MODE_SCAN_BIT     = 3;
  localparam logic [1:0]  MODE_HOST         = 2'h0;
  localparam logic [1:0]  MODE_ROM_ADDR     = 2'h1;
  localparam logic [1:0]  MODE_ROM_SERIAL   = 2'h2;
  localparam logic [1:0]  MODE_ROM_EXTADDR  = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 18'h00000;

  typedef enum logic [6:0] {
    CMC_IDLE   = 7'h01,
    CMC_CLEAR  = 7'h02,
    CMC_START  = 7'h04,
    CMC_LOAD   = 7'h08,
    CMC_DONE   = 7'h10,
    CMC_USER   = 7'h20,
    CMC_ERROR  = 7'h40
  } cmc_state_t;

  typedef struct packed {
    logic                wr;
    logic                rd;
    logic                osc_on;
    logic                boot_on;
    logic [DATA_W-1:0]   data;
  } cmc_host_cmd_t;
endpackage

//--- cmc_ctrl.sv
/*
 Configuration-load controller: decodes mode pins, reads configuration
 bytes or bits, checks error-check bytes of ROM boot loads, sequences oscillator and
 bootstrap, and releases user I/O.
 Assumes pins are asynchronous and sampled through two flip-flops;
 the configuration clock is an enable pulse derived from clk_sys.
*/
// The implementer's own choices: strobed register access.
// How it works
// - Low two mode bits pick host load or ROM boot one to three.
// - Mode bit 2 low drives internal clock out; high means external clock.
// - Mode bit 3 high enables scan and takes five user pins.
// - ROM boot one drives an 18-bit address and reads bytes.
// - ROM boot three reads bytes but drives no address.
// - ROM boot two reads one bit per transfer; memory self-addresses.
// - Load starts on power-up or external request in any mode.
// - Host load mode makes the device an eight-bit slave.
// - Host may write and read back configuration memory.
// - Any error-check byte mismatch stops loading and flags an error; host-mode loads are summed but never checked.
// - Bootstrap stays off during load, enabled only afterwards.
// - ROM boot sequences oscillator and bootstrap; host does in host mode.
// - Oscillator and bootstrap run 100 us before user I/O enables.
// - Host may switch the oscillator off, disabling bootstrap.
// - Configuration pins used by the mode stay dedicated after load.
// - Falling initiate edge, power-up or reset release starts a load.
// - memory_enable_n is low for the whole load sequence.
// - Checksum mismatch asserts open-drain load_error and halts; only ROM boot loads are checked.
// - User mode begins three clocks after power-up release and load_done.
`timescale 1ns/10ps
module cmc_ctrl #(
  parameter int unsigned SETTLE_CYC = cmc_pkg::OSC_SETTLE_CYC,
  parameter int unsigned ROW_BYTES  = cmc_pkg::ROW_BYTES,
  parameter int unsigned TOTAL_ROWS = cmc_pkg::TOTAL_ROWS
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [cmc_pkg::MODE_W-1:0]  mode_pins,
  input  wire logic                        rom_boot_n,
  input  wire logic                        power_up_release,
  input  wire logic                        cfg_clk_in,
  input  wire logic [cmc_pkg::DATA_W-1:0]  cfg_data_in,
  input  wire cmc_pkg::cmc_host_cmd_t      host_cmd,
  output logic                             cfg_clk_out,
  output logic                             cfg_clk_oe,
  output logic                             data_clk_out,
  output logic                             data_clk_oe,
  output logic [cmc_pkg::ADDR_W-1:0]       mem_addr,
  output logic                             mem_addr_oe,
  output logic                             memory_enable_n,
  output logic                             load_done,
  output logic                             load_error_out,
  output logic                             load_error_oe,
  output logic [cmc_pkg::DATA_W-1:0]       host_rd_data,
  output logic                             host_rd_valid,
  output logic                             scan_enable,
  output logic [cmc_pkg::SCAN_PINS-1:0]    user_pin_suspend,
  output logic                             dedicated_pins,
  output logic                             osc_enable,
  output logic                             bootstrap_enable,
  output logic                             user_in_enable,
  output logic                             user_out_enable
);
  localparam int unsigned BYTES_TOTAL = ROW_BYTES * TOTAL_ROWS;

  // Two-flop synchronisers; first stage feeds only the second
  logic [cmc_pkg::MODE_W-1:0] mode_s1, mode_s2;
  logic [cmc_pkg::DATA_W-1:0] data_s1, data_s2;
  logic boot_s1, boot_s2, boot_d, pwr_s1, pwr_s2, eclk_s1, eclk_s2, eclk_d;

  always_ff @(posedge clk_sys) begin
    mode_s1 <= mode_pins;
    mode_s2 <= mode_s1;
    data_s1 <= cfg_data_in;
    data_s2 <= data_s1;
    boot_s1 <= rom_boot_n;
    boot_s2 <= boot_s1;
    boot_d  <= boot_s2;
    pwr_s1  <= power_up_release;
    pwr_s2  <= pwr_s1;
    eclk_s1 <= cfg_clk_in;
    eclk_s2 <= eclk_s1;
    eclk_d  <= eclk_s2;
  end

  // Configuration clock enable: internal divider or external edge
  logic [$clog2(cmc_pkg::CCLK_DIV)-1:0] div, next_div;
  logic cclk_int, next_cclk_int;
  always_comb begin
    next_div      = div + 1'b1;
    next_cclk_int = cclk_int;
    if (div == '1)
      next_cclk_int = ~cclk_int;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div      <= '0;
      cclk_int <= 1'b0;
    end else begin
      div      <= next_div;
      cclk_int <= next_cclk_int;
    end
  end

  logic [cmc_pkg::MODE_W-1:0] mode_lat, next_mode_lat;
  wire ext_clk  = mode_lat[cmc_pkg::MODE_CLK_EXT_BIT];
  // External clock must keep running, else no edges are seen
  wire cclk_en  = ext_clk ? (eclk_s2 & ~eclk_d) : (div == '1 && !cclk_int);
  wire boot_fall = boot_d & ~boot_s2;

  cmc_pkg::cmc_state_t state, next_state;
  logic [cmc_pkg::ADDR_W-1:0] addr, next_addr;
  logic [15:0] byte_cnt, next_byte_cnt;
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  sum, next_sum;
  logic [$clog2(ROW_BYTES)-1:0] row_pos, next_row_pos;
  logic        phase, next_phase;
  logic [1:0]  tail, next_tail;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle, next_settle;
  logic        err, next_err, done, next_done;
  logic [7:0]  rx_byte;
  logic        rx_full;
  logic [7:0]  rd_data, next_rd_data;
  logic        rd_valid, next_rd_valid;
  logic        osc, next_osc, boot, next_boot;

  wire [1:0] sel = mode_lat[1:0];
  wire host_mode = (sel == cmc_pkg::MODE_HOST);
  wire serial    = (sel == cmc_pkg::MODE_ROM_SERIAL);
  wire settled   = (settle == SETTLE_CYC[$bits(settle)-1:0]);

  always_comb begin
    next_state    = state;
    next_mode_lat = mode_lat;
    next_addr     = addr;
    next_byte_cnt = byte_cnt;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_sum      = sum;
    next_row_pos  = row_pos;
    next_phase    = phase;
    next_tail     = tail;
    next_settle   = settle;
    next_err      = err;
    next_done     = done;
    rx_byte       = shreg;
    rx_full       = 1'b0;
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    next_osc      = osc;
    next_boot     = boot;
    if (boot_fall && state != cmc_pkg::CMC_CLEAR) begin
      next_state = cmc_pkg::CMC_CLEAR;
    end else begin
      unique case (state)
        cmc_pkg::CMC_IDLE: next_state = cmc_pkg::CMC_CLEAR;
        cmc_pkg::CMC_CLEAR: begin
          next_mode_lat = mode_s2;
          next_addr     = cmc_pkg::ADDR_RESET;
          next_byte_cnt = '0;
          next_bit_cnt  = '0;
          next_sum      = '0;
          next_row_pos  = '0;
          next_phase    = 1'b0;
          next_tail     = '0;
          next_settle   = '0;
          next_err      = 1'b0;
          next_done     = 1'b0;
          next_boot     = 1'b0;
          next_osc      = 1'b1;
          next_state    = cmc_pkg::CMC_START;
        end
        cmc_pkg::CMC_START: if (cclk_en) next_state = cmc_pkg::CMC_LOAD;
        cmc_pkg::CMC_LOAD: begin
          if (host_mode) begin
            // Host drives the whole load and owns the oscillator enable; bootstrap is held off
            if (host_cmd.wr) begin
              next_shreg = host_cmd.data;
              next_sum   = sum + host_cmd.data;
            end
            if (host_cmd.rd) begin
              next_rd_data  = shreg;
              next_rd_valid = 1'b1;
            end
            next_osc  = host_cmd.osc_on;
            // Pump stays shunted while memory is written
            next_boot = 1'b0;
            if (host_cmd.wr && host_cmd.data == 8'h00 && host_cmd.boot_on) begin
              next_boot  = host_cmd.osc_on;
              next_state = cmc_pkg::CMC_DONE;
            end
          end else if (cclk_en) begin
            // Latch as the data clock rises, so the memory steps only after a byte or bit is taken
            next_phase = ~phase;
            if (!phase) begin
              rx_byte = serial ? {shreg[6:0], data_s2[0]} : data_s2;
              rx_full = !serial || bit_cnt == 3'h7;
              next_bit_cnt = serial ? bit_cnt + 3'h1 : 3'h0;
              next_shreg   = rx_byte;
              if (sel == cmc_pkg::MODE_ROM_ADDR)
                next_addr = addr + 1'b1;
              if (rx_full) begin
                next_byte_cnt = byte_cnt + 16'h1;
                next_row_pos  = row_pos + 1'b1;
                next_sum      = sum + rx_byte;
                if (row_pos == ROW_BYTES[$bits(row_pos)-1:0] - 1'b1) begin
                  next_sum = '0;
                  if (rx_byte != sum) begin
                    next_err   = 1'b1;
                    next_state = cmc_pkg::CMC_ERROR;
                  end else if (byte_cnt == BYTES_TOTAL[15:0] - 16'h1) begin
                    next_done  = 1'b1;
                    next_state = cmc_pkg::CMC_DONE;
                  end
                end
              end
            end
          end
        end
        cmc_pkg::CMC_DONE: begin
          next_done = 1'b1;
          if (!host_mode) begin
            next_osc  = 1'b1;
            next_boot = 1'b1;
          end else begin
            // Host owns both enables once the load is over
            next_osc  = host_cmd.osc_on;
            next_boot = host_cmd.boot_on & host_cmd.osc_on;
          end
          if (boot && !settled)
            next_settle = settle + 1'b1;
          if (cclk_en && pwr_s2 && settled) begin
            next_tail = tail + 2'h1;
            if (tail == 2'(cmc_pkg::USER_DELAY_CLKS - 1))
              next_state = cmc_pkg::CMC_USER;
          end
        end
        cmc_pkg::CMC_USER:  next_state = cmc_pkg::CMC_USER;
        cmc_pkg::CMC_ERROR: next_state = cmc_pkg::CMC_ERROR;
        default:            next_state = cmc_pkg::CMC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state    <= cmc_pkg::CMC_IDLE;
      mode_lat <= '0;
      addr     <= cmc_pkg::ADDR_RESET;
      byte_cnt <= '0;
      bit_cnt  <= '0;
      shreg    <= '0;
      sum      <= '0;
      row_pos  <= '0;
      phase    <= 1'b0;
      tail     <= '0;
      settle   <= '0;
      err      <= 1'b0;
      done     <= 1'b0;
      rd_data  <= '0;
      rd_valid <= 1'b0;
      osc      <= 1'b0;
      boot     <= 1'b0;
    end else begin
      state    <= next_state;
      mode_lat <= next_mode_lat;
      addr     <= next_addr;
      byte_cnt <= next_byte_cnt;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      sum      <= next_sum;
      row_pos  <= next_row_pos;
      phase    <= next_phase;
      tail     <= next_tail;
      settle   <= next_settle;
      err      <= next_err;
      done     <= next_done;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      osc      <= next_osc;
      boot     <= next_boot;
    end
  end

  wire loading = (state == cmc_pkg::CMC_START) || (state == cmc_pkg::CMC_LOAD);
  assign cfg_clk_out      = cclk_int;
  assign cfg_clk_oe       = ~ext_clk;
  assign data_clk_out     = phase;
  assign data_clk_oe      = loading && !host_mode;
  assign mem_addr         = addr;
  assign mem_addr_oe      = loading && sel == cmc_pkg::MODE_ROM_ADDR;
  assign memory_enable_n  = ~(loading || state == cmc_pkg::CMC_DONE);
  assign load_done        = done;
  assign load_error_out   = 1'b0;
  assign load_error_oe    = err;
  assign host_rd_data     = rd_data;
  assign host_rd_valid    = rd_valid;
  assign scan_enable      = mode_s2[cmc_pkg::MODE_SCAN_BIT];
  assign user_pin_suspend = {cmc_pkg::SCAN_PINS{scan_enable}};
  assign dedicated_pins   = state != cmc_pkg::CMC_IDLE;
  assign osc_enable       = osc;
  assign bootstrap_enable = boot;
  assign user_in_enable   = state == cmc_pkg::CMC_USER;
  assign user_out_enable  = state == cmc_pkg::CMC_USER;

  a_boot_off_load: assert property (@(posedge clk_sys) disable iff (rst)
    loading |-> !bootstrap_enable) else $error("bootstrap on during load");
  a_memory_enable_n_load: assert property (@(posedge clk_sys) disable iff (rst)
    loading |-> !memory_enable_n) else $error("memory enable high in load");
  a_err_halts: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cmc_pkg::CMC_ERROR && !boot_fall) |=> load_error_oe && !load_done) else $error("error not held");
  a_user_after: assert property (@(posedge clk_sys) disable iff (rst)
    user_out_enable |-> settled && osc_enable && bootstrap_enable) else $error("user early");
  a_addr_mode: assert property (@(posedge clk_sys) disable iff (rst)
    (sel != cmc_pkg::MODE_ROM_ADDR) |-> !mem_addr_oe) else $error("address driven");
  a_clk_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cmc_pkg::CMC_START && ext_clk && !(eclk_s2 && !eclk_d) && !boot_fall)
    |=> state == cmc_pkg::CMC_START) else $error("start without clock edge");
  a_mode_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (state == cmc_pkg::CMC_LOAD && !boot_fall) |=> $stable(mode_lat)) else $error("mode changed");
  a_start_edge: assert property (@(posedge clk_sys) disable iff (rst)
    boot_fall |=> state == cmc_pkg::CMC_CLEAR ##1 memory_enable_n == 1'b0) else $error("no restart");
endmodule

//--- cmc_rom_model.sv
/* Configuration store model: byte ROM with internal or external
   addressing, or serial memory. Assumes DCLK rising edges advance it. */
`timescale 1ns/10ps
module cmc_rom_model #(
  parameter int ROW_BYTES  = 4,
  parameter int TOTAL_ROWS = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [1:0]  mode,
  input  wire logic [17:0] mem_addr,
  input  wire logic        data_clk_out,
  input  wire logic        data_clk_oe,
  input  wire logic        corrupt,
  output logic [7:0]       data
);
  localparam int SIZE = ROW_BYTES * TOTAL_ROWS;
  logic [7:0]  image [SIZE];
  logic [7:0]  last;
  logic [7:0]  cur;
  logic [20:0] cnt;
  logic        dclk_q;
  int          idx;
  // Last byte of each row is the plain sum of the others
  initial begin
    for (int r = 0; r < TOTAL_ROWS; r++) begin
      image[r*ROW_BYTES+ROW_BYTES-1] = 8'h00;
      for (int b = 0; b < ROW_BYTES-1; b++) begin
        image[r*ROW_BYTES+b] = 8'h3C + 8'(b*21 + r*64);
        image[r*ROW_BYTES+ROW_BYTES-1] += image[r*ROW_BYTES+b];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    dclk_q <= data_clk_out;
    last <= data;
    if (rst || !data_clk_oe) begin
      cnt <= '0;
    end else if (data_clk_out && !dclk_q) begin
      cnt <= cnt + 21'h1;
    end
  end
  always_comb begin
    idx = (mode == 2'h1) ? int'(mem_addr) : (mode == 2'h2) ? int'(cnt >> 3) : int'(cnt);
    cur = image[idx % SIZE];
    if (corrupt && (idx % ROW_BYTES) == ROW_BYTES-1) begin
      cur = cur ^ 8'h01;
    end
    // Released bus shows no stale value
    if (!data_clk_oe) begin
      data = ~last;
    end else if (mode == 2'h2) begin
      data = {~last[7:1], cur[3'h7 - cnt[2:0]]};
    end else begin
      data = cur;
    end
  end
endmodule

//--- testbench.sv
/* Self-checking bench for the configuration-load controller.
   Assumes cmc_pkg and the ROM model are compiled first. */
`timescale 1ns/10ps
module testbench;
  localparam int SETTLE = 20;
  typedef struct packed {
    logic [3:0] mode;
    logic       addr_oe;
    logic       clk_oe;
    logic       scan;
  } cmc_row_t;
  cmc_row_t rows [6] = '{'{4'h1, 1'b1, 1'b1, 1'b0}, '{4'h2, 1'b0, 1'b1, 1'b0}, '{4'h3, 1'b0, 1'b1, 1'b0},
                         '{4'h5, 1'b1, 1'b0, 1'b0}, '{4'hE, 1'b0, 1'b0, 1'b1}, '{4'h9, 1'b1, 1'b1, 1'b1}};
  logic                   clk_sys = 1'b0;
  logic                   rst = 1'b1;
  logic [3:0]             mode_pins = 4'h1;
  logic                   rom_boot_n = 1'b1;
  logic                   power_up_release = 1'b0;
  logic                   cfg_clk_in = 1'b0;
  logic                   corrupt = 1'b0;
  logic [1:0]             rom_mode = 2'h1;
  logic                   rom_active = 1'b1;
  logic                   user_q = 1'b0;
  logic                   cclk_seen;
  cmc_pkg::cmc_host_cmd_t host_cmd = '0;
  logic [7:0]             cfg_data_in, host_rd_data;
  logic [17:0]            mem_addr;
  logic [4:0]             user_pin_suspend;
  logic                   cfg_clk_out, cfg_clk_oe, data_clk_out, data_clk_oe, mem_addr_oe, memory_enable_n;
  logic                   load_done, load_error_out, load_error_oe, host_rd_valid, scan_enable, dedicated_pins;
  logic                   osc_enable, bootstrap_enable, user_in_enable, user_out_enable;
  int                     settle_cnt = 0;
  int                     fail_count = 0;
  int                     n_compared = 0;

  cmc_ctrl #(.SETTLE_CYC(SETTLE), .ROW_BYTES(4), .TOTAL_ROWS(2)) dut (
    .clk_sys(clk_sys), .rst(rst), .mode_pins(mode_pins), .rom_boot_n(rom_boot_n),
    .power_up_release(power_up_release), .cfg_clk_in(cfg_clk_in), .cfg_data_in(cfg_data_in),
    .host_cmd(host_cmd), .cfg_clk_out(cfg_clk_out), .cfg_clk_oe(cfg_clk_oe), .data_clk_out(data_clk_out),
    .data_clk_oe(data_clk_oe), .mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe), .memory_enable_n(memory_enable_n),
    .load_done(load_done), .load_error_out(load_error_out), .load_error_oe(load_error_oe),
    .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid), .scan_enable(scan_enable),
    .user_pin_suspend(user_pin_suspend), .dedicated_pins(dedicated_pins), .osc_enable(osc_enable),
    .bootstrap_enable(bootstrap_enable), .user_in_enable(user_in_enable), .user_out_enable(user_out_enable));
  cmc_rom_model #(.ROW_BYTES(4), .TOTAL_ROWS(2)) rom (
    .clk_sys(clk_sys), .rst(rst), .mode(rom_mode), .mem_addr(mem_addr), .data_clk_out(data_clk_out),
    .data_clk_oe(data_clk_oe), .corrupt(corrupt), .data(cfg_data_in));

  always #5 clk_sys = ~clk_sys;
  // External clock runs free so pin transitions are always seen
  always #40 cfg_clk_in = ~cfg_clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return !memory_enable_n;
      1: return load_done | load_error_oe;
      default: return user_in_enable;
    endcase
  endfunction

  // Bounded wait, then the awaited flag itself is checked
  task automatic wait_for(input int w, input int lim);
    int i;
    i = 0;
    while (sel(w) !== 1'b1 && i < lim) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    chk(sel(w), 1'b1);
  endtask

  task automatic start_load(input logic [3:0] m);
    @(posedge clk_sys);
    mode_pins  <= m;
    rom_mode   <= m[1:0];
    rom_active <= (m[1:0] != 2'h0);
    cyc(4);
    rom_boot_n <= 1'b0;
    cyc(3);
    rom_boot_n <= 1'b1;
    // Old done and error flags clear only four edges after rom_boot_n falls
    cyc(2);
    wait_for(0, 200);
  endtask

  task automatic host_op(input logic w, input logic r, input logic o, input logic b, input logic [7:0] d);
    @(posedge clk_sys);
    host_cmd <= '{wr: w, rd: r, osc_on: o, boot_on: b, data: d};
    @(posedge clk_sys);
    host_cmd.wr <= 1'b0;
    host_cmd.rd <= 1'b0;
  endtask

  always @(posedge clk_sys) begin
    if (!rst && rom_active && !memory_enable_n && load_done === 1'b0 && bootstrap_enable === 1'b1)
      chk(bootstrap_enable, 1'b0);
    if (osc_enable === 1'b1 && bootstrap_enable === 1'b1) settle_cnt++;
    else settle_cnt = 0;
    if (rom_active && user_in_enable === 1'b1 && user_q !== 1'b1) chk(settle_cnt >= SETTLE, 1'b1);
    user_q = user_in_enable;
  end

  initial begin
    #800000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    cyc(12);
    chk({memory_enable_n, osc_enable, bootstrap_enable, user_in_enable, load_done, load_error_oe}, 6'h20);
    rst <= 1'b0;
    wait_for(0, 50);
    cclk_seen = cfg_clk_out;
    cyc(8);
    #1;
    chk(cfg_clk_out, !cclk_seen);
    wait_for(1, 5000);
    cyc(60);
    chk({load_done, user_in_enable}, 2'b10);
    power_up_release <= 1'b1;
    wait_for(2, 100);
    for (int i = 0; i < 6; i++) begin
      start_load(rows[i].mode);
      cyc(2);
      chk(mem_addr_oe, rows[i].addr_oe);
      chk(cfg_clk_oe, rows[i].clk_oe);
      chk({scan_enable, user_pin_suspend}, {6{rows[i].scan}});
      chk({data_clk_oe, dedicated_pins}, 2'b11);
      wait_for(1, 20000);
      chk({load_done, load_error_oe}, 2'b10);
      wait_for(2, 400);
      cyc(2);
      chk({user_out_enable, memory_enable_n, mem_addr_oe}, 3'b110);
    end
    start_load(4'h1);
    @(posedge clk_sys);
    mode_pins <= 4'h3;
    cyc(40);
    chk(mem_addr_oe, 1'b1);
    wait_for(1, 5000);
    corrupt <= 1'b1;
    start_load(4'h1);
    wait_for(1, 5000);
    cyc(50);
    chk({load_done, load_error_oe, load_error_out, user_in_enable}, 4'b0100);
    corrupt <= 1'b0;
    start_load(4'h3);
    wait_for(1, 5000);
    chk({load_done, load_error_oe}, 2'b10);
    start_load(4'h0);
    chk({mem_addr_oe, data_clk_oe}, 2'b00);
    // Host commands are refused until the first config clock ends the start state
    cyc(20);
    host_op(1'b1, 1'b0, 1'b1, 1'b0, 8'h5A);
    host_op(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    #1;
    chk({host_rd_valid, host_rd_data}, 9'h15A);
    host_op(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    cyc(3);
    chk({osc_enable, bootstrap_enable}, 2'b00);
    host_op(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    cyc(3);
    chk(osc_enable, 1'b1);
    host_op(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    wait_for(1, 200);
    chk(load_done, 1'b1);
    tally_and_finish();
  end
endmodule
